// *** hw/reset_powerdown_ctrl.v ***
`timescale 1ns/10ps
`include "rpd_consts.vh"
// Contract
// - pm2 bits 2-6 disconnect control inputs
// - apd counts held ale, request after 15
// - power-up loads config, clears, sets operating
// - stay in reset for recovery after release
// - memories enter read mode at power-up
// - block eeprom strobes about 5ms after power-up
// - no flash write below lockout
// - array outputs valid after config load
// - pin states in resets and power-down
// - macrocells cleared by power-on reset only
// - other registers clear on both resets; power registers clear at power-up only, map reloads config
// - memory map from config, two bits zero
// - test pins dedicated when any enable true
// - pins inputs until enabling command arrives
// - enable register at c7h, set/clear rules
// - configuration commands only, no boundary scan
// - push and open-drain enable commands turn on extension pins; basic enable does not
// - error low on flash failure, sticky
// - status low while programming in progress
// - blank part enables test pins
// - bit 0 enables port, others zero
// - reset aborts register-enabled test operations
// - power registers clear only at power-up
module reset_powerdown_ctrl #(
  parameter EEH_CYCLES = `EEH_CYCLES // eeprom strobe block length
) (
  input wire clk, // device clock, 10 MHz
  input wire rstn, // internal power-on reset, active low
  input wire reset_pin_n, // external reset pin, active low
  input wire [7:0] reg_addr, // register offset
  input wire [7:0] reg_wdata, // write data
  input wire reg_wr, // write strobe, one cycle
  input wire reg_rd, // read strobe, one cycle
  output reg [7:0] reg_rdata, // read data
  input wire bus_ctrl_in_a, // bus control input a
  input wire bus_ctrl_in_b, // bus control input b
  input wire bus_ctrl_in_c, // bus control input c
  input wire ale_in, // address latch enable
  input wire data_byte_en_in, // data byte enable
  input wire ale_pd_polarity, // ale level that counts
  input wire [7:0] mem_map_cfg, // configured memory map value
  input wire nvm_test_bit, // nonvolatile test dedication
  input wire blank_part, // part is blank or erased
  input wire test_pin_select_term, // product term enable
  input wire vcc_lockout, // supply below lockout threshold
  input wire flash_write_req, // flash write cycle request
  input wire eeprom_strobe_in, // eeprom write strobe
  input wire flash_fail, // flash erase or program failure
  input wire mem_busy, // flash or eeprom write busy
  input wire tck, // serial clock pin
  input wire tms, // mode select pin
  input wire tdi, // serial data in pin
  output reg array_ctrl_a, // gated control input a
  output reg array_ctrl_b, // gated control input b
  output reg array_ctrl_c, // gated control input c
  output reg array_ale, // gated address latch enable
  output reg array_dbe, // gated data byte enable
  output reg powerdown_request, // automatic power-down
  output reg mem_read_mode, // memories in read mode
  output reg mem_access_ok, // first access allowed
  output reg flash_write_start, // flash write cycle begins
  output reg eeprom_strobe_out, // strobe to eeprom array
  output reg array_out_valid, // logic array outputs valid
  output reg mcell_clear, // macrocell flip-flop clear
  output reg mcu_io_input, // mcu i/o forced to input
  output reg addr_out_hiz, // address-out pins tri-state
  output reg data_port_hiz, // data port tri-state
  output reg periph_io_hiz, // peripheral i/o tri-state
  output reg test_pins_on, // four pins dedicated to test
  output wire tdo_out, // serial data out value
  output wire tdo_oe_n, // low while tdo drives
  output wire stat_out, // program status pin value
  output wire stat_oe_n, // low while status drives
  output wire err_out, // program error pin value
  output wire err_oe_n // low while error drives
);
  // one-hot sequence states
  localparam [3:0] ST_LOAD = 4'h1; // loading configuration
  localparam [3:0] ST_HOLD = 4'h2; // reset pin held low
  localparam [3:0] ST_RECOVER = 4'h4; // recovery interval
  localparam [3:0] ST_RUN = 4'h8; // operating
  localparam integer OPR_FULL = `OPR_CYCLES; // recovery count, full width
  localparam [15:0] OPR_CNT = OPR_FULL[15:0]; // recovery count
  localparam [22:0] EEH_CNT = EEH_CYCLES[22:0]; // eeprom block count

  reg [3:0] state; // sequence state
  reg [15:0] seq_cnt; // load and recovery counter
  reg [22:0] eeh_cnt; // eeprom block counter
  reg [1:0] rst_s; // reset pin sync
  reg [1:0] a_s, b_s, c_s, ale_s, dbe_s; // control syncs
  reg [1:0] lko_s, sel_s; // lockout and term syncs
  reg ale_d; // previous ale for toggle detect
  reg [3:0] apd_cnt; // power-down counter
  reg [7:0] power_mgmt_reg_first; // apd enable and clocks
  reg [7:0] power_mgmt_reg_second; // input gating
  reg [7:0] test_port_enable; // runtime test enable
  reg [7:0] memory_map_reg; // memory map
  reg warm_pulse; // one cycle at warm reset entry
  wire in_reset = ~state[3]; // any reset phase
  wire apd_en = power_mgmt_reg_first[`PM1_APD_BIT];
  wire test_abort = in_reset & ~nvm_test_bit;

  // decode of an offset against a strobe
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    input stb;
    begin
      hit = stb & (addr == ofs);
    end
  endfunction

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // reset, control, ale, dbe, lockout and term pins cross into clk through two flops before any use
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s <= 2'h0;
      a_s <= 2'h0;
      b_s <= 2'h0;
      c_s <= 2'h0;
      ale_s <= 2'h0;
      dbe_s <= 2'h0;
      lko_s <= 2'h3;
      sel_s <= 2'h0;
    end else begin
      rst_s <= {rst_s[0], reset_pin_n};
      a_s <= {a_s[0], bus_ctrl_in_a};
      b_s <= {b_s[0], bus_ctrl_in_b};
      c_s <= {c_s[0], bus_ctrl_in_c};
      ale_s <= {ale_s[0], ale_in};
      dbe_s <= {dbe_s[0], data_byte_en_in};
      lko_s <= {lko_s[0], vcc_lockout};
      sel_s <= {sel_s[0], test_pin_select_term};
    end
  end

  // ------------------------------------------------------------
  // reset sequence
  // ------------------------------------------------------------
  // config load phase
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_LOAD;
      seq_cnt <= 16'h0000;
      warm_pulse <= 1'b0;
    end else begin
      warm_pulse <= 1'b0;
      case (state)
        ST_LOAD: begin
          seq_cnt <= seq_cnt + 16'h0001;
          if (seq_cnt[3:0] == `CFG_LOAD_CYCLES) begin
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          seq_cnt <= 16'h0000;
          if (rst_s[1]) begin
            state <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          seq_cnt <= seq_cnt + 16'h0001;
          if (!rst_s[1]) begin
            state <= ST_HOLD;
          end else if (seq_cnt + 16'h0001 >= OPR_CNT) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          // warm reset: a much shorter pulse is enough
          if (!rst_s[1]) begin
            state <= ST_HOLD;
            warm_pulse <= 1'b1;
          end
        end
        default: begin
          state <= ST_LOAD;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // power registers only on power-up
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      power_mgmt_reg_first <= `ZERO8;
      power_mgmt_reg_second <= `ZERO8;
    end else if (!in_reset) begin
      if (hit(reg_addr, `OFS_PM_FIRST, reg_wr)) begin
        power_mgmt_reg_first <= reg_wdata & `PM1_MASK;
      end
      if (hit(reg_addr, `OFS_PM_SECOND, reg_wr)) begin
        power_mgmt_reg_second <= reg_wdata & `PM2_MASK;
      end
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      test_port_enable <= `ZERO8;
      memory_map_reg <= `ZERO8;
    end else if (in_reset) begin
      test_port_enable <= `ZERO8;
      // map from configuration
      // strap is sampled by the clock while reset is held
      memory_map_reg <= mem_map_cfg & `MM_FORCE_MASK;
    end else begin
      if (hit(reg_addr, `OFS_TEST_EN, reg_wr)) begin
        test_port_enable <= reg_wdata & `TEN_MASK;
      end
      if (hit(reg_addr, `OFS_MEM_MAP, reg_wr)) begin
        memory_map_reg <= reg_wdata;
      end
    end
  end

  // read port, unmapped offsets read zero
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= `ZERO8;
    end else if (hit(reg_addr, `OFS_PM_FIRST, reg_rd)) begin
      reg_rdata <= power_mgmt_reg_first;
    end else if (hit(reg_addr, `OFS_PM_SECOND, reg_rd)) begin
      reg_rdata <= power_mgmt_reg_second;
    end else if (hit(reg_addr, `OFS_TEST_EN, reg_rd)) begin
      reg_rdata <= test_port_enable;
    end else if (hit(reg_addr, `OFS_MEM_MAP, reg_rd)) begin
      reg_rdata <= memory_map_reg;
    end else begin
      reg_rdata <= `ZERO8;
    end
  end

  // ------------------------------------------------------------
  // automatic power-down
  // ------------------------------------------------------------
  // count held ale
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ale_d <= 1'b0;
      apd_cnt <= 4'h0;
      powerdown_request <= 1'b0;
    end else begin
      ale_d <= ale_s[1];
      if (!apd_en || ale_s[1] != ale_d || ale_s[1] != ale_pd_polarity) begin
        apd_cnt <= 4'h0;
        powerdown_request <= 1'b0;
      end else if (apd_cnt != `APD_LIMIT) begin
        apd_cnt <= apd_cnt + 4'h1;
        powerdown_request <= (apd_cnt + 4'h1) == `APD_LIMIT;
      end
    end
  end

  // ------------------------------------------------------------
  // gating, memory and pin status
  // ------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      array_ctrl_a <= 1'b0;
      array_ctrl_b <= 1'b0;
      array_ctrl_c <= 1'b0;
      array_ale <= 1'b0;
      array_dbe <= 1'b0;
      mem_read_mode <= 1'b0;
      mem_access_ok <= 1'b0;
      flash_write_start <= 1'b0;
      array_out_valid <= 1'b0;
      mcell_clear <= 1'b1;
      mcu_io_input <= 1'b1;
      addr_out_hiz <= 1'b1;
      data_port_hiz <= 1'b1;
      periph_io_hiz <= 1'b1;
      test_pins_on <= 1'b0;
    end else begin
      array_ctrl_a <= a_s[1] & ~power_mgmt_reg_second[`PM2_GATE_A];
      array_ctrl_b <= b_s[1] & ~power_mgmt_reg_second[`PM2_GATE_B];
      array_ctrl_c <= c_s[1] & ~power_mgmt_reg_second[`PM2_GATE_C];
      array_ale <= ale_s[1] & ~power_mgmt_reg_second[`PM2_GATE_ALE];
      array_dbe <= dbe_s[1] & ~power_mgmt_reg_second[`PM2_GATE_DBE];
      mem_read_mode <= ~state[0];
      mem_access_ok <= state[3];
      flash_write_start <= flash_write_req & ~lko_s[1] & state[3];
      array_out_valid <= ~state[0];
      mcell_clear <= state[0];
      mcu_io_input <= in_reset;
      addr_out_hiz <= in_reset;
      data_port_hiz <= in_reset | powerdown_request;
      periph_io_hiz <= in_reset | powerdown_request;
      test_pins_on <= nvm_test_bit | blank_part | sel_s[1] |
        test_port_enable[`TEN_BIT];
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eeh_cnt <= 23'h00_0000;
      eeprom_strobe_out <= 1'b0;
    end else begin
      if (eeh_cnt != EEH_CNT) begin
        eeh_cnt <= eeh_cnt + 23'h00_0001;
      end
      eeprom_strobe_out <= eeprom_strobe_in & (eeh_cnt == EEH_CNT) & state[3];
    end
  end

  // ------------------------------------------------------------
  // serial test port
  // ------------------------------------------------------------
  test_port_ctrl u_test_port (
    .clk(clk),
    .rstn(rstn),
    .tck_raw(tck),
    .tms_raw(tms),
    .tdi_raw(tdi),
    .test_on(test_pins_on),
    .abort(test_abort),
    .chip_reset(warm_pulse),
    .flash_fail(flash_fail),
    .mem_busy(mem_busy),
    .tdo_out(tdo_out),
    .tdo_oe_n(tdo_oe_n),
    .stat_out(stat_out),
    .stat_oe_n(stat_oe_n),
    .err_out(err_out),
    .err_oe_n(err_oe_n)
  );
endmodule // reset_powerdown_ctrl

// *** hw/rpd_consts.vh ***
`ifndef RPD_CONSTS_VH
`define RPD_CONSTS_VH
// register offsets on the microcontroller register port
`define OFS_PM_FIRST 8'hb0
`define OFS_PM_SECOND 8'hb4
`define OFS_TEST_EN 8'hc7
`define OFS_MEM_MAP 8'he0
// field positions
`define PM1_APD_BIT 1
`define PM2_GATE_A 2
`define PM2_GATE_B 3
`define PM2_GATE_C 4
`define PM2_GATE_ALE 5
`define PM2_GATE_DBE 6
`define TEN_BIT 0
`define MM_CODE_FETCH_BIT 0
`define MM_PERIPH_BIT 7
// reset values and masks
`define ZERO8 8'h00
`define MM_FORCE_MASK 8'h7e
`define PM1_MASK 8'h3a
`define PM2_MASK 8'h7c
`define TEN_MASK 8'h01
// timing
`define CLK_NS 100
`define APD_LIMIT 4'hf
`define CFG_LOAD_CYCLES 4'h8
`define OPR_NS 200
`define OPR_CYCLES ((`OPR_NS + `CLK_NS - 1) / `CLK_NS)
`define EEH_NS 5000000
`define EEH_CYCLES (`EEH_NS / `CLK_NS)
// serial test port commands
`define CMD_EN_PUSH 8'h10
`define CMD_EN_OPEN 8'h11
`define CMD_EN_BASIC 8'h12
`define CMD_DISABLE 8'h20
`define CMD_CLEAR 8'h30
`endif

// *** hw/test_port_ctrl.v ***
`timescale 1ns/10ps
`include "rpd_consts.vh"
// serial configuration port: command shifter and extension pins
module test_port_ctrl (
  input wire clk, // device clock
  input wire rstn, // power-on reset, active low
  input wire tck_raw, // serial clock pin
  input wire tms_raw, // mode select pin
  input wire tdi_raw, // serial data in pin
  input wire test_on, // pins dedicated to test use
  input wire abort, // reset that stops test operations
  input wire chip_reset, // one-cycle warm reset pulse
  input wire flash_fail, // flash erase or program failed
  input wire mem_busy, // flash or eeprom write in progress
  output reg tdo_out, // serial data out value
  output reg tdo_oe_n, // low while tdo drives
  output reg stat_out, // ready/busy value
  output reg stat_oe_n, // low while status drives
  output reg err_out, // error value, low on failure
  output reg err_oe_n // low while error drives
);
  reg [2:0] tck_s; // tck sync, bit 2 is edge history
  reg [1:0] tms_s; // tms sync
  reg [1:0] tdi_s; // tdi sync
  reg tms_d; // previous synced tms
  reg [7:0] shifter; // command shift register
  reg active; // channel enabled by command
  reg ext_en; // extension pins enabled
  reg open_drain; // extension pins open-drain
  reg err_flag; // sticky flash error
  reg disabled_seen; // disable command was seen
  wire tck_rise = tck_s[1] & ~tck_s[2];
  wire tck_fall = ~tck_s[1] & tck_s[2];
  wire cmd_end = tms_d & ~tms_s[1];
  wire run = test_on & ~abort;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // first stage feeds only the second stage
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tck_s <= 3'h0;
      tms_s <= 2'h0;
      tdi_s <= 2'h0;
      tms_d <= 1'b0;
    end else begin
      tck_s <= {tck_s[1:0], tck_raw};
      tms_s <= {tms_s[0], tms_raw};
      tdi_s <= {tdi_s[0], tdi_raw};
      if (tck_rise) begin
        tms_d <= tms_s[1];
      end
    end
  end

  // ------------------------------------------------------------
  // command shifting and execution
  // ------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shifter <= `ZERO8;
      active <= 1'b0;
      ext_en <= 1'b0;
      open_drain <= 1'b0;
      disabled_seen <= 1'b0;
    end else if (!run) begin
      // reset aborts
      // register-enabled port drops shifter, active and ext_en on reset; open_drain is kept
      shifter <= `ZERO8;
      active <= 1'b0;
      ext_en <= 1'b0;
      disabled_seen <= disabled_seen & ~chip_reset;
    end else if (tck_rise && tms_s[1]) begin
      // lsb first
      shifter <= {tdi_s[1], shifter[7:1]};
    end else if (tck_rise && cmd_end) begin
      // config commands only
      // no boundary scan codes are decoded
      case (shifter)
        `CMD_EN_PUSH: begin
          active <= 1'b1;
          ext_en <= 1'b1;
          open_drain <= 1'b0;
        end
        `CMD_EN_OPEN: begin
          active <= 1'b1;
          ext_en <= 1'b1;
          open_drain <= 1'b1;
        end
        `CMD_EN_BASIC: begin
          active <= 1'b1;
          ext_en <= 1'b0;
        end
        `CMD_DISABLE: begin
          active <= 1'b0;
          ext_en <= 1'b0;
          disabled_seen <= 1'b1;
        end
        default: begin
          // unknown codes are ignored
          active <= active;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // sticky flash error
  // ------------------------------------------------------------
  // error set and clear
  // a failure in the clearing cycle still sets the flag
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_flag <= 1'b0;
    end else if (flash_fail) begin
      err_flag <= 1'b1;
    end else if (run && tck_rise && cmd_end && shifter == `CMD_CLEAR) begin
      err_flag <= 1'b0;
    end else if (chip_reset && disabled_seen) begin
      err_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tdo_out <= 1'b0;
      tdo_oe_n <= 1'b1;
      stat_out <= 1'b1;
      stat_oe_n <= 1'b1;
      err_out <= 1'b1;
      err_oe_n <= 1'b1;
    end else begin
      // tdo changes on the falling serial clock edge
      if (tck_fall) begin
        tdo_out <= shifter[0];
      end
      tdo_oe_n <= ~(run & active);
      stat_out <= ~mem_busy;
      err_out <= ~err_flag;
      // open-drain only pulls low, for wired-or chains
      stat_oe_n <= ~(run & ext_en & (~open_drain | mem_busy));
      err_oe_n <= ~(run & ext_en & (~open_drain | err_flag));
    end
  end
endmodule // test_port_ctrl

// *** test/prog_cable_model.sv ***
`timescale 1ns/10ps
// ------
// serial programming controller
// ------
module prog_cable_model (
  output logic tck, // serial clock, still between frames
  output logic tms, // mode select
  output logic tdi, // serial data, lsb first
  output logic cable_enable_signal // cable asks for the pins
);
  initial begin
    tck = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
    cable_enable_signal = 1'b0;
  end
  // cable enable drives the select term
  task automatic set_en(input logic e);
    cable_enable_signal = e;
  endtask
  task automatic send_cmd(input logic [7:0] c);
    for (int i = 0; i < 9; i++) begin
      tms = (i < 8);
      tdi = (i < 8) ? c[i] : ~tdi;
      #400 tck = 1'b1;
      #400 tck = 1'b0;
    end
    // idle data flips so no stale bit is read
    tdi = ~tdi;
  endtask
endmodule // prog_cable_model

// *** test/reset_powerdown_ctrl_tb.sv ***
`timescale 1ns/10ps
`include "rpd_consts.vh"
// ------
// bench for reset, power-down and test port
// ------
module reset_powerdown_ctrl_tb;
  localparam EEH = 20; // short strobe block
  logic clk = '0, rstn = '0, reset_pin_n = '1, reg_wr = '0, reg_rd = '0;
  logic [7:0] reg_addr = '0, reg_wdata = '0, mem_map_cfg = '0, reg_rdata, v;
  logic bus_ctrl_in_a = '0, bus_ctrl_in_b = '0, bus_ctrl_in_c = '0, ale_in = '0;
  logic data_byte_en_in = '0, ale_pd_polarity = '0, nvm_test_bit = '0, blank_part = '0;
  logic vcc_lockout = '0, flash_write_req = '0, eeprom_strobe_in = '0, flash_fail = '0;
  logic mem_busy = '0, test_pin_select_term, tck, tms, tdi, array_ctrl_a, array_ctrl_b;
  logic array_ctrl_c, array_ale, array_dbe, powerdown_request, mem_read_mode;
  logic mem_access_ok, flash_write_start, eeprom_strobe_out, array_out_valid;
  logic mcell_clear, mcu_io_input, addr_out_hiz, data_port_hiz, periph_io_hiz;
  logic test_pins_on, tdo_out, tdo_oe_n, stat_out, stat_oe_n, err_out, err_oe_n;
  int n_fail = 0, n_checks = 0, seed = 32'h63c5_c132;
  reset_powerdown_ctrl #(.EEH_CYCLES(EEH)) dut (.*);
  prog_cable_model cable (.tck(tck), .tms(tms), .tdi(tdi),
    .cable_enable_signal(test_pin_select_term));
  always #50 clk = ~clk;
  task automatic report_and_stop;
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // inputs move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    chk(nm, e, reg_rdata);
    cyc(1);
  endtask
  // bounded wait for the run state
  task automatic warm;
    reset_pin_n = 1'b0;
    wr(`OFS_TEST_EN, 8'h01);
    cyc(5);
    chk("mcu_io_input", 8'h01, {7'h00, mcu_io_input});
    chk("addr_hiz", 8'h01, {7'h00, addr_out_hiz});
    reset_pin_n = 1'b1;
    for (int i = 0; i < 60 && mem_access_ok !== 1'b1; i++) cyc(1);
  endtask
  function automatic logic [7:0] gate_exp(input int b);
    return 8'h1f & ~(8'h01 << (b - 2));
  endfunction
  initial begin
    #500_000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    mem_map_cfg = $random(seed);
    cyc(5); // strobes held low
    chk("mcell_clear", 8'h01, {7'h00, mcell_clear});
    rstn = 1'b1;
    for (int i = 0; i < 60 && mem_access_ok !== 1'b1; i++) cyc(1);
    chk("read_mode", 8'h01, {7'h00, mem_read_mode});
    chk("out_valid", 8'h03, {6'h00, array_out_valid, ~mcell_clear});
    rdc("mem_map", `OFS_MEM_MAP, mem_map_cfg & 8'h7e);
    rdc("test_en", `OFS_TEST_EN, 8'h00);
    rdc("unmapped", 8'h55, 8'h00);
    eeprom_strobe_in = 1'b1;
    cyc(EEH);
    chk("ee_strobe", 8'h01, {7'h00, eeprom_strobe_out});
    eeprom_strobe_in = 1'b0;
    flash_write_req = 1'b1;
    cyc(3);
    chk("flash_start", 8'h01, {7'h00, flash_write_start});
    vcc_lockout = 1'b1;
    cyc(5);
    chk("flash_start", 8'h00, {7'h00, flash_write_start});
    vcc_lockout = 1'b0;
    {bus_ctrl_in_a, bus_ctrl_in_b, bus_ctrl_in_c, ale_in, data_byte_en_in} = 5'h1f;
    for (int b = 2; b < 7; b++) begin
      wr(`OFS_PM_SECOND, 8'h01 << b);
      cyc(4);
      chk("gates", gate_exp(b), {3'h0, array_dbe, array_ale, array_ctrl_c,
        array_ctrl_b, array_ctrl_a});
    end
    v = $random(seed);
    wr(`OFS_PM_FIRST, v | 8'h02);
    ale_pd_polarity = $random(seed);
    ale_in = ale_pd_polarity;
    cyc(20);
    chk("pd_req", 8'h07, {5'h00, powerdown_request, data_port_hiz, periph_io_hiz});
    chk("mcu_io_pd", 8'h00, {7'h00, mcu_io_input});
    repeat (20) begin
      ale_in = ~ale_in;
      cyc(1);
    end
    chk("pd_pulse", 8'h00, {7'h00, powerdown_request});
    cyc(20);
    wr(`OFS_PM_FIRST, v & 8'hfd);
    cyc(3);
    chk("pd_off", 8'h00, {7'h00, powerdown_request});
    wr(`OFS_TEST_EN, 8'hff);
    rdc("test_en", `OFS_TEST_EN, 8'h01);
    chk("pins", 8'h03, {6'h00, test_pins_on, tdo_oe_n});
    cable.send_cmd(`CMD_EN_PUSH);
    mem_busy = 1'b1;
    cyc(4);
    chk("stat", 8'h00, {5'h00, tdo_oe_n, stat_oe_n, stat_out});
    mem_busy = 1'b0;
    flash_fail = 1'b1;
    cyc(1);
    flash_fail = 1'b0;
    cyc(4);
    chk("err", 8'h00, {err_oe_n, err_out});
    cable.send_cmd(`CMD_CLEAR);
    cyc(5);
    chk("err_clr", 8'h01, {err_oe_n, err_out});
    cable.send_cmd(`CMD_EN_OPEN);
    cyc(5);
    chk("err_od", 8'h07, {tdo_out, err_oe_n, err_out});
    flash_fail = 1'b1;
    cyc(1);
    flash_fail = 1'b0;
    cable.send_cmd(`CMD_DISABLE);
    chk("err_kept", 8'h00, {7'h00, err_out});
    mem_map_cfg = $random(seed);
    warm;
    chk("pins_off", 8'h00, {7'h00, test_pins_on});
    chk("err_warm", 8'h01, {7'h00, err_out});
    rdc("pm1", `OFS_PM_FIRST, v & 8'h38);
    rdc("pm2", `OFS_PM_SECOND, 8'h40);
    rdc("mem_map", `OFS_MEM_MAP, mem_map_cfg & 8'h7e);
    blank_part = 1'b1;
    cyc(3);
    chk("blank", 8'h01, {7'h00, test_pins_on});
    blank_part = 1'b0;
    cable.set_en(1'b1); // cable drives select term
    cyc(4);
    chk("term", 8'h01, {7'h00, test_pins_on});
    cable.set_en(1'b0);
    nvm_test_bit = 1'b1;
    cable.send_cmd(`CMD_EN_BASIC);
    cyc(5);
    warm;
    chk("nvm_kept", 8'h00, {7'h00, tdo_oe_n});
    report_and_stop;
  end
endmodule // reset_powerdown_ctrl_tb

// *** test/rpd_checker.sv ***
`timescale 1ns/10ps
`include "rpd_consts.vh"
// ------
// checker on the top ports
// ------
module rpd_checker #(
  parameter EEH_CYCLES = 20 // strobe block, cycles
) (
  input wire clk, // clock
  input wire rstn, // power-on reset
  input wire reset_pin_n, // warm reset pin
  input wire [7:0] reg_addr, // offset
  input wire [7:0] reg_wdata, // write data
  input wire reg_wr, // write strobe
  input wire ale_in, // latch enable
  input wire ale_pd_polarity, // counting level
  input wire vcc_lockout, // low supply
  input wire mem_busy, // write busy
  input wire array_ctrl_a, // gated input a
  input wire powerdown_request, // apd request
  input wire mem_access_ok, // run state
  input wire mem_read_mode, // read mode
  input wire flash_write_start, // flash write
  input wire eeprom_strobe_out, // eeprom strobe
  input wire test_pins_on, // test pins on
  input wire tdo_oe_n, // tdo enable
  input wire stat_out, // status value
  input wire stat_oe_n // status enable
);
  reg ale_q; // last latch enable
  reg [4:0] ale_cnt; // steady cycles at counting level
  reg [15:0] ee_cnt; // cycles since power-on release
  // both saturate so a long run never wraps them
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ale_q <= 1'b0;
      ale_cnt <= 5'h00;
      ee_cnt <= 16'h0000;
    end else begin
      ale_q <= ale_in;
      if (ale_in != ale_q || ale_in != ale_pd_polarity) begin
        ale_cnt <= 5'h00;
      end else if (ale_cnt != 5'h1f) begin
        ale_cnt <= ale_cnt + 5'h01;
      end
      if (ee_cnt < EEH_CYCLES) begin
        ee_cnt <= ee_cnt + 16'h0001;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // enable write and warm reset pulse
  sequence s_te_write;
    reg_wr && mem_access_ok && reg_addr == `OFS_TEST_EN && reg_wdata[0];
  endsequence
  sequence s_pin_pulse;
    !reset_pin_n [*4] ##1 reset_pin_n;
  endsequence
  property p_gate; reg_wr && mem_access_ok && reg_addr == `OFS_PM_SECOND && reg_wdata[2]
    |-> ##[1:4] !array_ctrl_a; endproperty
  a_gate: assert property (p_gate) else $error("gated input passed");
  property p_pd_rise; $rose(powerdown_request) |-> ale_cnt >= 5'h0f; endproperty
  a_pd_rise: assert property (p_pd_rise) else $error("early power-down");
  property p_pd_drop; powerdown_request && $changed(ale_in) |-> ##[1:4] !powerdown_request;
  endproperty
  a_pd_drop: assert property (p_pd_drop) else $error("request kept");
  property p_load; $rose(rstn) |-> (!mem_access_ok && !mem_read_mode) [*8]; endproperty
  a_load: assert property (p_load) else $error("load phase short");
  property p_warm; s_pin_pulse |-> !mem_access_ok [*3]; endproperty
  a_warm: assert property (p_warm) else $error("no recovery");
  property p_lock; vcc_lockout [*4] |-> !flash_write_start; endproperty
  a_lock: assert property (p_lock) else $error("write under lockout");
  property p_ee; eeprom_strobe_out |-> ee_cnt >= EEH_CYCLES - 1; endproperty
  a_ee: assert property (p_ee) else $error("strobe too early");
  property p_stat; (!stat_oe_n && mem_busy) [*4] |-> !stat_out; endproperty
  a_stat: assert property (p_stat) else $error("status high while busy");
  property p_tdo; !test_pins_on [*2] |-> tdo_oe_n; endproperty
  a_tdo: assert property (p_tdo) else $error("tdo driven");
  property p_ten; s_te_write |-> ##[2:3] test_pins_on; endproperty
  a_ten: assert property (p_ten) else $error("pins not on");
endmodule // rpd_checker
bind reset_powerdown_ctrl rpd_checker #(.EEH_CYCLES(EEH_CYCLES)) chk_i (.*);
